/* rtl/vcb_input_bandsplit.sv */
// input selection, bandsplit and line-tap generation feeding the adaptive comb filter
//
// Function
// - either video port may be routed to primary or secondary channel by register
// - sign invert bit flips msb of second port input to two's complement; with msb control set it flips the secondary channel msb after routing
// - low band is low-pass of video, high band is video minus low band
// - two low-pass responses chosen by lowpass select, independent of video standard
// - comb taps use high band for chroma comb, full band for luma comb
// - every line tap provides low, high and full band signals
// - primary channel carries undelayed composite or the selected separated component
// - secondary channel carries field or frame delayed composite or other component
// - line combs pass delayed high and low bands through second store
// - chroma comb stores all high band bits but only upper low band bits
// - luma comb stores equal high and low bits and sums them for outer tap
// - store partition bit sets the high and low bit split of second store
// - first store bypass bit high makes the first line store bypassed
// - separated inputs: secondary skips the comb and feeds the flat selector
// - latency one line plus 38 pixels for three-line combs, else 38
// - flat signal is a delayed copy of the comb input
// - separated component mode makes the flat selector take secondary data
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vcb_input_bandsplit import vcb_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [VID_W-1:0] i_port_a,
    input wire logic [VID_W-1:0] i_port_b,
    input vcb_axil_req_s i_axi,
    output vcb_axil_rsp_s o_axi,
    output vcb_taps_s o_taps,
    output vcb_comb_s o_comb,
    output logic [VID_W-1:0] o_flat
);
    typedef struct packed {
        logic [2:0][VID_W-1:0] a_sync;
        logic [2:0][VID_W-1:0] b_sync;
        logic [VID_W-1:0] a_st;
        logic [VID_W-1:0] b_st;
        logic [VID_W-1:0] prim;
        logic [VID_W-1:0] sec;
        logic [VID_W-1:0] line;
        logic [SPLIT_LAT-1:0][VID_W-1:0] sec_pipe;
        vcb_out_s [PAD_LEN-1:0] pipe;
        logic [ADDR_W-1:0] pix_cnt;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [CTRL_W-1:0] ctrl;
        logic [ADDR_W-1:0] line_len;
    } vcb_top_state_s;

    vcb_top_state_s st_ff;
    vcb_top_state_s nxt_st;
    vcb_band_s band0;
    vcb_band_s band1;
    vcb_band_s band2;
    logic [VID_W-1:0] store1_rd;
    logic [VID_W-1:0] split1_in;
    logic [2*VID_W-1:0] store2_wr;
    logic [2*VID_W-1:0] store2_rd;
    logic [VID_W-1:0] a_in;
    logic [VID_W-1:0] b_in;
    logic [VID_W-1:0] prim_src;
    logic [VID_W-1:0] sec_src;
    vcb_out_s entry;
    logic [AGE_W-1:0] cfg_age_ff;

    // byte-lane merge of a write into a narrow register
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [HB_W-1:0] comb_pick(input vcb_band_s b, input logic luma);
        return luma ? HB_W'(b.full) : b.high;
    endfunction

    // first tap and middle tap filters, second store and first store
    vcb_band_splitter u_split0 (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_lowpass_select(st_ff.ctrl[CB_LOWPASS]),
        .i_video(st_ff.prim),
        .o_band(band0)
    );

    vcb_line_store #(.DATA_W(VID_W)) u_store1 (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_line_len(st_ff.line_len),
        .i_wr_data(st_ff.line),
        .o_rd_data(store1_rd)
    );

    assign split1_in = st_ff.ctrl[CB_BYPASS] ? st_ff.line : store1_rd;

    vcb_band_splitter u_split1 (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_lowpass_select(st_ff.ctrl[CB_LOWPASS]),
        .i_video(split1_in),
        .o_band(band1)
    );

    // chroma split keeps every high bit and the upper low bits, luma split keeps equal halves
    always_comb begin
        if (st_ff.ctrl[CB_SPLIT]) begin
            store2_wr = {band1.high[HB_W-1 -: VID_W], band1.low};
            band2.high = {store2_rd[2*VID_W-1 -: VID_W], 1'b0};
            band2.low = store2_rd[VID_W-1:0];
        end else begin
            store2_wr = {band1.high, band1.low[VID_W-1 -: LOW_KEEP]};
            band2.high = store2_rd[2*VID_W-1 -: HB_W];
            band2.low = {store2_rd[LOW_KEEP-1:0], 1'b0};
        end
        band2.full = VID_W'(band2.low + band2.high);
    end

    vcb_line_store #(.DATA_W(2*VID_W)) u_store2 (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_line_len(st_ff.line_len),
        .i_wr_data(store2_wr),
        .o_rd_data(store2_rd)
    );

    always_comb begin
        // input conditioning and port routing
        a_in = st_ff.a_st;
        b_in = st_ff.b_st;
        if (st_ff.ctrl[CB_SIGN_INV] && !st_ff.ctrl[CB_MSB_CTL]) begin
            b_in[VID_W-1] = ~st_ff.b_st[VID_W-1];
        end
        prim_src = st_ff.ctrl[CB_PORT_MUX] ? b_in : a_in;
        sec_src = st_ff.ctrl[CB_PORT_MUX] ? a_in : b_in;
        if (st_ff.ctrl[CB_SIGN_INV] && st_ff.ctrl[CB_MSB_CTL]) begin
            sec_src[VID_W-1] = ~sec_src[VID_W-1];
        end
        // tap assembly
        entry.taps.t0 = band0;
        entry.taps.t1 = band1;
        entry.taps.t2 = band2;
        entry.comb.c0 = comb_pick(band0, st_ff.ctrl[CB_LUMA_COMB]);
        entry.comb.c1 = comb_pick(band1, st_ff.ctrl[CB_LUMA_COMB]);
        entry.comb.c2 = comb_pick(band2, st_ff.ctrl[CB_LUMA_COMB]);
        if (st_ff.ctrl[CB_SEP_COMP]) begin
            entry.flat = st_ff.sec_pipe[SPLIT_LAT-1];
        end else if (st_ff.ctrl[CB_THREE_LINE]) begin
            entry.flat = band1.full;
        end else begin
            entry.flat = band0.full;
        end

        nxt_st = st_ff;
        // pin synchronisers: a new word counts once stages two and three agree
        nxt_st.a_sync[0] = i_port_a;
        nxt_st.b_sync[0] = i_port_b;
        nxt_st.a_sync[2:1] = st_ff.a_sync[1:0];
        nxt_st.b_sync[2:1] = st_ff.b_sync[1:0];
        if (st_ff.a_sync[1] == st_ff.a_sync[2]) begin
            nxt_st.a_st = st_ff.a_sync[2];
        end
        if (st_ff.b_sync[1] == st_ff.b_sync[2]) begin
            nxt_st.b_st = st_ff.b_sync[2];
        end
        // one sample per clock through every stage
        nxt_st.prim = prim_src;
        nxt_st.sec = sec_src;
        nxt_st.line = st_ff.ctrl[CB_STORE_IN] ? sec_src : prim_src;
        nxt_st.sec_pipe[0] = st_ff.sec;
        for (int i = 1; i < SPLIT_LAT; i++) begin
            nxt_st.sec_pipe[i] = st_ff.sec_pipe[i-1];
        end
        // padding brings every path to the fixed pixel latency
        nxt_st.pipe[0] = entry;
        for (int i = 1; i < PAD_LEN; i++) begin
            nxt_st.pipe[i] = st_ff.pipe[i-1];
        end
        if (st_ff.pix_cnt >= st_ff.line_len - 1'b1) begin
            nxt_st.pix_cnt = '0;
        end else begin
            nxt_st.pix_cnt = st_ff.pix_cnt + 1'b1;
        end

        // register slave: address and data may arrive in either order
        if (i_axi.awvalid && o_axi.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && o_axi.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = i_axi.wdata;
            nxt_st.wstrb = i_axi.wstrb;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            case (st_ff.awaddr)
                REG_CTRL: begin
                    nxt_st.ctrl = CTRL_W'(merge_bytes(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb));
                end
                REG_LINE: begin
                    nxt_st.line_len = ADDR_W'(merge_bytes(32'(st_ff.line_len), st_ff.wdata, st_ff.wstrb));
                end
                REG_STAT: begin
                    nxt_st.bresp = RESP_OKAY;
                end
                default: begin
                    nxt_st.bresp = RESP_SLVERR;
                end
            endcase
        end else if (st_ff.bvalid && i_axi.bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (i_axi.arvalid && o_axi.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            case (i_axi.araddr)
                REG_CTRL: begin
                    nxt_st.rdata = 32'(st_ff.ctrl);
                end
                REG_LINE: begin
                    nxt_st.rdata = 32'(st_ff.line_len);
                end
                REG_STAT: begin
                    nxt_st.rdata = 32'(st_ff.pix_cnt);
                end
                default: begin
                    nxt_st.rdata = '0;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_ff.rvalid && i_axi.rready) begin
            nxt_st.rvalid = 1'b0;
        end

        if (!i_nrst) begin
            nxt_st = '0;
            nxt_st.ctrl = CTRL_RST;
            nxt_st.line_len = LINE_LEN_RST;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st_ff <= nxt_st;
    end

    always_comb begin
        o_axi.awready = !st_ff.aw_got && !st_ff.bvalid;
        o_axi.wready = !st_ff.w_got && !st_ff.bvalid;
        o_axi.bvalid = st_ff.bvalid;
        o_axi.bresp = st_ff.bresp;
        o_axi.arready = !st_ff.rvalid;
        o_axi.rvalid = st_ff.rvalid;
        o_axi.rdata = st_ff.rdata;
        o_axi.rresp = st_ff.rresp;
    end

    assign o_taps = st_ff.pipe[PAD_LEN-1].taps;
    assign o_comb = st_ff.pipe[PAD_LEN-1].comb;
    assign o_flat = st_ff.pipe[PAD_LEN-1].flat;

    // cycles since the configuration last changed, saturating
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || nxt_st.ctrl != st_ff.ctrl || nxt_st.line_len != st_ff.line_len) begin
            cfg_age_ff <= '0;
        end else if (cfg_age_ff != '1) begin
            cfg_age_ff <= cfg_age_ff + 1'b1;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence seq_write_pair;
        st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    endsequence

    sequence seq_settled;
        cfg_age_ff >= LAT_PIX && !st_ff.ctrl[CB_PORT_MUX] && !st_ff.ctrl[CB_SIGN_INV];
    endsequence

    property p_flat_from(logic cond, logic [VID_W-1:0] src);
        (seq_settled and cond) |-> o_flat == $past(src, LAT_PIX);
    endproperty

    chk_ctrl_write: assert property ((seq_write_pair and st_ff.awaddr == REG_CTRL && st_ff.wstrb == 4'hf)
        |=> st_ff.ctrl == $past(st_ff.wdata[CTRL_W-1:0]) && o_axi.bvalid)
        else $error("control write not applied");
    chk_bad_read: assert property ((i_axi.arvalid && o_axi.arready && i_axi.araddr != REG_CTRL
        && i_axi.araddr != REG_LINE && i_axi.araddr != REG_STAT) |=> o_axi.rvalid && o_axi.rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_port_route: assert property ($past(!st_ff.ctrl[CB_PORT_MUX]) |-> st_ff.prim == $past(st_ff.a_st))
        else $error("primary channel not taken from port a");
    chk_sign_invert: assert property (($past(st_ff.ctrl[CB_SIGN_INV]) && !$past(st_ff.ctrl[CB_MSB_CTL])
        && !$past(st_ff.ctrl[CB_PORT_MUX])) |-> st_ff.sec[VID_W-1] != $past(st_ff.b_st[VID_W-1]))
        else $error("second port msb not inverted");
    chk_band_sum: assert property (VID_W'(o_taps.t0.low + o_taps.t0.high) == o_taps.t0.full
        && VID_W'(o_taps.t1.low + o_taps.t1.high) == o_taps.t1.full)
        else $error("low and high bands do not sum to full band");
    chk_flat_sep: assert property (p_flat_from(st_ff.ctrl[CB_SEP_COMP], st_ff.b_st))
        else $error("flat not secondary data in separated mode");
    chk_flat_latency: assert property (p_flat_from(!st_ff.ctrl[CB_SEP_COMP] && !st_ff.ctrl[CB_THREE_LINE],
        st_ff.a_st))
        else $error("flat latency differs from fixed pixel latency");
    chk_comb_taps: assert property (cfg_age_ff >= LAT_PIX |-> o_comb.c0 == (st_ff.ctrl[CB_LUMA_COMB] ?
        HB_W'(o_taps.t0.full) : o_taps.t0.high))
        else $error("comb tap source wrong");
    chk_bypass_path: assert property ((seq_settled and st_ff.ctrl[CB_BYPASS] && st_ff.ctrl[CB_STORE_IN])
        |-> o_taps.t1.full == $past(st_ff.b_st, LAT_PIX))
        else $error("first store not bypassed");
endmodule // vcb_input_bandsplit

/* rtl/vcb_pkg.sv */
// shared constants, register map and carrier types for the comb input bandsplit block
package vcb_pkg;
    localparam int VID_W = 10;
    localparam int HB_W = VID_W + 1;
    localparam int SUM_W = VID_W + 3;
    localparam int LOW_KEEP = 2 * VID_W - HB_W;
    localparam int ADDR_W = 11;
    localparam int LINE_DEPTH = 2 ** ADDR_W;
    localparam int SPLIT_TAPS = 5;
    localparam int SPLIT_LAT = 4;
    localparam int LAT_PIX = 38;
    localparam int PAD_LEN = LAT_PIX - 1 - SPLIT_LAT;
    localparam int AGE_W = 6;
    localparam logic [ADDR_W-1:0] LINE_LEN_RST = 11'h35a;
    localparam logic [ADDR_W-1:0] STORE_WRAP_OFS = 11'h002;
    // register map
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_LINE = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STAT = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register fields
    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam int CB_PORT_MUX = 0;
    localparam int CB_SIGN_INV = 1;
    localparam int CB_MSB_CTL = 2;
    localparam int CB_LOWPASS = 3;
    localparam int CB_SPLIT = 4;
    localparam int CB_STORE_IN = 5;
    localparam int CB_BYPASS = 6;
    localparam int CB_SEP_COMP = 7;
    localparam int CB_LUMA_COMB = 8;
    localparam int CB_THREE_LINE = 9;

    typedef struct packed {
        logic [VID_W-1:0] full;
        logic [VID_W-1:0] low;
        logic [HB_W-1:0] high;
    } vcb_band_s;

    typedef struct packed {
        vcb_band_s t0;
        vcb_band_s t1;
        vcb_band_s t2;
    } vcb_taps_s;

    typedef struct packed {
        logic [HB_W-1:0] c0;
        logic [HB_W-1:0] c1;
        logic [HB_W-1:0] c2;
    } vcb_comb_s;

    typedef struct packed {
        vcb_taps_s taps;
        vcb_comb_s comb;
        logic [VID_W-1:0] flat;
    } vcb_out_s;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } vcb_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } vcb_axil_rsp_s;
endpackage

/* rtl/vcb_line_store.sv */
// one-line delay memory with registered read data
`timescale 1ns/1ps
module vcb_line_store import vcb_pkg::*; #(
    parameter int DATA_W = VID_W
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_line_len,
    input wire logic [DATA_W-1:0] i_wr_data,
    output logic [DATA_W-1:0] o_rd_data
);
    typedef struct packed {
        logic [ADDR_W-1:0] ptr;
        logic [DATA_W-1:0] rd;
        logic filled;
    } vcb_store_state_s;

    vcb_store_state_s st_ff;
    vcb_store_state_s nxt_st;
    logic [DATA_W-1:0] mem [LINE_DEPTH];

    // read-before-write at one pointer: period line_len-1 plus the read register gives line_len
    always_comb begin
        nxt_st = st_ff;
        // until the first wrap the memory holds nothing written, so read zeros
        nxt_st.rd = st_ff.filled ? mem[st_ff.ptr] : '0;
        if (st_ff.ptr >= i_line_len - STORE_WRAP_OFS) begin
            nxt_st.ptr = '0;
            nxt_st.filled = 1'b1;
        end else begin
            nxt_st.ptr = st_ff.ptr + 1'b1;
        end
        if (!i_nrst) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st_ff <= nxt_st;
        mem[st_ff.ptr] <= i_wr_data;
    end

    assign o_rd_data = st_ff.rd;
endmodule // vcb_line_store

/* rtl/vcb_band_splitter.sv */
// complementary bandsplit filter with two selectable low-pass responses
`timescale 1ns/1ps
module vcb_band_splitter import vcb_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_lowpass_select,
    input wire logic [VID_W-1:0] i_video,
    output vcb_band_s o_band
);
    typedef struct packed {
        logic [SPLIT_TAPS-1:0][VID_W-1:0] tap;
        vcb_band_s band;
    } vcb_split_state_s;

    vcb_split_state_s st_ff;
    vcb_split_state_s nxt_st;
    logic [SUM_W-1:0] sum_narrow;
    logic [SUM_W-1:0] sum_wide;
    logic [VID_W-1:0] low;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tap[0] = i_video;
        for (int i = 1; i < SPLIT_TAPS; i++) begin
            nxt_st.tap[i] = st_ff.tap[i-1];
        end
        // both responses are centred on tap 2, so the delay match is shared
        sum_narrow = SUM_W'(st_ff.tap[1]) + SUM_W'({st_ff.tap[2], 1'b0}) + SUM_W'(st_ff.tap[3]);
        sum_wide = SUM_W'(st_ff.tap[0]) + SUM_W'({st_ff.tap[1], 1'b0}) + SUM_W'({st_ff.tap[2], 1'b0})
            + SUM_W'({st_ff.tap[3], 1'b0}) + SUM_W'(st_ff.tap[4]);
        low = i_lowpass_select ? sum_wide[SUM_W-1 -: VID_W] : sum_narrow[SUM_W-2 -: VID_W];
        nxt_st.band.low = low;
        nxt_st.band.full = st_ff.tap[2];
        nxt_st.band.high = {1'b0, st_ff.tap[2]} - {1'b0, low};
        if (!i_nrst) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st_ff <= nxt_st;
    end

    assign o_band = st_ff.band;
endmodule // vcb_band_splitter

/* tb/vcb_video_src.sv */
// video source model driving both ports of the block
`timescale 1ns/1ps
module vcb_video_src import vcb_pkg::*; #(
    parameter int HOLD = 4
) (
    input wire logic i_sys_clk,
    input wire logic [VID_W-1:0] i_next_a,
    input wire logic [VID_W-1:0] i_next_b,
    output logic [VID_W-1:0] o_port_a,
    output logic [VID_W-1:0] o_port_b
);
    int cnt = 0;
    initial begin
        o_port_a = '0;
        o_port_b = '0;
    end
    // words are held so the agreeing sync stages always accept them
    always @(posedge i_sys_clk) begin
        cnt <= (cnt + 1) % HOLD;
        if (cnt == 0) begin
            o_port_a <= i_next_a;
            o_port_b <= i_next_b;
        end
    end
endmodule // vcb_video_src

/* tb/tb_video_comb_input_bandsplit.sv */
// self-checking bench for the comb input bandsplit block
`timescale 1ns/1ps
module tb_video_comb_input_bandsplit import vcb_pkg::*; ();
    localparam int LN = 8;
    localparam logic [23:0] TBL[12] = '{
        {10'h000, 3'h0, 11'h123}, {10'h001, 3'h0, 11'h2c4}, {10'h080, 3'h0, 11'h2c4},
        {10'h081, 3'h0, 11'h123}, {10'h082, 3'h0, 11'h0c4}, {10'h002, 3'h0, 11'h123},
        {10'h003, 3'h0, 11'h0c4}, {10'h060, 3'h1, 11'h123}, {10'h060, 3'h2, 11'h2c4},
        {10'h000, 3'h3, 11'h123}, {10'h008, 3'h3, 11'h123}, {10'h008, 3'h4, 11'h000}};
    localparam logic [9:0] RCFG[5] = '{10'h000, 10'h100, 10'h008, 10'h200, 10'h308};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    vcb_axil_req_s req = '0;
    vcb_axil_rsp_s rsp;
    vcb_taps_s taps;
    vcb_comb_s comb;
    logic [VID_W-1:0] flat, pa, pb;
    logic [VID_W-1:0] na = '0, nb = '0;
    logic [33:0] q[$];
    logic [VID_W-1:0] hf[LN];
    logic [HB_W-1:0] hh[LN];
    logic [31:0] seed = 32'hfb2ac9d4;
    logic pon = 1'b0, rel_on = 1'b0, rnd_on = 1'b0;
    logic [2:0] psel = '0;
    logic [CTRL_W-1:0] cfg = '0;
    int bad_count = 0, samples_checked = 0, age = 0;

    always #5 clk = ~clk;

    vcb_video_src src_u (.i_sys_clk(clk), .i_next_a(na), .i_next_b(nb), .o_port_a(pa), .o_port_b(pb));
    vcb_input_bandsplit dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_port_a(pa), .i_port_b(pb),
        .i_axi(req), .o_axi(rsp), .o_taps(taps), .o_comb(comb), .o_flat(flat));

    task automatic check(input logic [33:0] s, input logic [33:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("wrong value at %0t: no answer in time", $time);
        summarize();
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [10:0] pick(input logic [2:0] s);
        case (s)
            3'h0: return {1'b0, flat};
            3'h1: return {1'b0, taps.t0.full};
            3'h2: return {1'b0, taps.t1.full};
            3'h3: return {1'b0, taps.t0.low};
            default: return taps.t0.high;
        endcase
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        q.push_back({er, 32'h0});
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (n > 50) hang();
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        int n;
        n = 0;
        q.push_back(e);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (n > 50) hang();
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
    endtask

    task automatic probe(input logic [2:0] s, input logic [10:0] e);
        q.push_back({23'h0, e});
        @(posedge clk);
        psel <= s;
        pon <= 1'b1;
        @(posedge clk);
        pon <= 1'b0;
    endtask

    task automatic note(input logic [33:0] s);
        if (q.size() == 0) hang();
        check(s, q.pop_front());
    endtask

    always @(posedge clk) begin
        if (rsp.bvalid && req.bready) note({rsp.bresp, 32'h0});
        if (rsp.rvalid && req.rready) note({rsp.rresp, rsp.rdata});
        if (pon) note({23'h0, pick(psel)});
        if (rnd_on) begin
            seed <= lfsr(seed);
            na <= seed[9:0];
            nb <= seed[25:16];
        end
    end

    // per-sample relations between the tap outputs while random video flows
    always @(negedge clk) begin
        if (!rel_on) begin
            age = 0;
        end else begin
            age++;
            check({24'h0, taps.t0.low + taps.t0.high[9:0]}, {24'h0, taps.t0.full});
            check({23'h0, comb.c0}, {23'h0, cfg[CB_LUMA_COMB] ? {1'b0, taps.t0.full} : taps.t0.high});
            check({23'h0, comb.c1}, {23'h0, cfg[CB_LUMA_COMB] ? {1'b0, taps.t1.full} : taps.t1.high});
            check({23'h0, comb.c2}, {23'h0, cfg[CB_LUMA_COMB] ? {1'b0, taps.t2.full} : taps.t2.high});
            check({24'h0, flat}, {24'h0, cfg[CB_THREE_LINE] ? taps.t1.full : taps.t0.full});
            if (age > LN) begin
                check({24'h0, taps.t1.full}, {24'h0, hf[LN-1]});
                if (!cfg[CB_LUMA_COMB]) check({23'h0, taps.t2.high}, {23'h0, hh[LN-1]});
            end
        end
        for (int i = LN - 1; i > 0; i--) begin
            hf[i] = hf[i-1];
            hh[i] = hh[i-1];
        end
        hf[0] = taps.t0.full;
        hh[0] = taps.t1.high;
    end

    initial begin
        repeat (20000) @(posedge clk);
        hang();
    end

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        axr(REG_CTRL, {RESP_OKAY, 22'h0, CTRL_RST});
        axr(REG_LINE, {RESP_OKAY, 21'h0, LINE_LEN_RST});
        axr(8'h0c, {RESP_SLVERR, 32'h0});
        axw(8'h0c, 32'h1, RESP_SLVERR);
        axw(REG_STAT, 32'h5, RESP_OKAY);
        axw(REG_LINE, 32'(LN), RESP_OKAY);
        axr(REG_LINE, {RESP_OKAY, 32'(LN)});
        axw(REG_CTRL, 32'hffffffff, RESP_OKAY);
        axr(REG_CTRL, {RESP_OKAY, 22'h0, 10'h3ff});
        na <= 10'h123;
        nb <= 10'h2c4;
        foreach (TBL[i]) begin
            axw(REG_CTRL, {22'h0, TBL[i][23:14]}, RESP_OKAY);
            repeat (90) @(posedge clk);
            probe(TBL[i][13:11], TBL[i][10:0]);
        end
        rnd_on <= 1'b1;
        foreach (RCFG[i]) begin
            cfg = RCFG[i];
            axw(REG_CTRL, {22'h0, cfg}, RESP_OKAY);
            repeat (90) @(posedge clk);
            rel_on <= 1'b1;
            repeat (200) @(posedge clk);
            rel_on <= 1'b0;
        end
        summarize();
    end
endmodule // tb_video_comb_input_bandsplit
